// ==== wia_pkg.sv ====
// windowed input averager: shared constants, register map and carrier types
// assumes one pclk domain; register offsets are byte addresses on a 32-bit apb
package wia_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int WIA_NCH = 4;
  localparam int WIA_CHW = 2;
  localparam int WIA_DW = 24;
  localparam int WIA_SUMW = 32;
  localparam int WIA_NW = 8;
  localparam int WIA_WW = 16;
  localparam int WIA_IDXW = 8;
  localparam int WIA_AW = 8;
  localparam int WIA_DIV_STEPS = 32;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [WIA_AW-1:0] WIA_OFF_CAL_CODE = 8'h00;
  localparam logic [WIA_AW-1:0] WIA_OFF_COUNT = 8'h04;
  localparam logic [WIA_AW-1:0] WIA_OFF_WIDTH = 8'h08;
  localparam logic [WIA_AW-1:0] WIA_OFF_STATUS = 8'h0C;
  localparam logic [WIA_AW-1:0] WIA_OFF_LAST = 8'h10;

  // calibration code as a plain binary number, 22X = 220 + channel digit
  localparam logic [11:0] WIA_CAL_CODE_RST = 12'h000;
  localparam logic [11:0] WIA_CODE_CH_FIRST = 12'h0DD;
  localparam logic [11:0] WIA_CODE_CH_LAST = 12'h0E0;

  localparam logic [WIA_NW-1:0] WIA_N_RST = 8'h01;
  localparam logic [WIA_NW-1:0] WIA_N_MIN = 8'h01;
  localparam logic [WIA_WW-1:0] WIA_W_RST = 16'hFFFF;
  localparam logic [WIA_WW-1:0] WIA_W_MIN = 16'h0001;

  localparam int WIA_ST_BUSY = 0;
  localparam int WIA_ST_SEL_OK = 1;
  localparam int WIA_ST_AVG_LSB = 4;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [WIA_CHW-1:0] chan;
    logic [WIA_DW-1:0] data;
  } wia_sample_t;

  typedef struct packed {
    logic [WIA_CHW-1:0] chan;
    logic averaged;
    logic [WIA_DW-1:0] data;
  } wia_result_t;

  typedef enum logic [4:0] {
    WIA_IDLE = 5'b00001,
    WIA_FETCH = 5'b00010,
    WIA_DIV = 5'b00100,
    WIA_OUT = 5'b01000,
    WIA_SPARE = 5'b10000
  } wia_state_t;

endpackage

// ==== wia_hist.sv ====
// wia_hist: sample history for all channels, one ring slot per sample
// assumes writer and reader on pclk; read data appears one edge after raddr
`timescale 1ns/100ps
module wia_hist
  import wia_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [WIA_CHW+WIA_IDXW-1:0] waddr,
  input wire logic [WIA_DW-1:0] wdata,
  input wire logic [WIA_CHW+WIA_IDXW-1:0] raddr,
  output logic [WIA_DW-1:0] rdata
);

  // no reset on the array: a slot is only read after it was written
  logic [WIA_DW-1:0] mem [WIA_NCH*(2**WIA_IDXW)];

  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ==== wia_div.sv ====
// wia_div: signed by unsigned restoring divider, truncates toward zero
// assumes divisor is never zero when start is pulsed; done is a one-cycle pulse
`timescale 1ns/100ps
module wia_div
  import wia_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [WIA_SUMW-1:0] dividend,
  input wire logic [WIA_NW-1:0] divisor,
  output logic done,
  output logic [WIA_SUMW-1:0] quotient
);

  logic busy, next_busy;
  logic neg, next_neg;
  logic [5:0] step, next_step;
  logic [WIA_SUMW-1:0] mag, next_mag;
  logic [WIA_NW:0] rem, next_rem;
  logic [WIA_NW-1:0] dvs, next_dvs;
  logic next_done;
  logic [WIA_SUMW-1:0] next_quotient;

  always_comb
  begin
    logic [WIA_NW:0] shifted;
    logic bit_q;
    shifted = {rem[WIA_NW-1:0], mag[WIA_SUMW-1]};
    bit_q = shifted >= {1'b0, dvs};
    next_busy = busy;
    next_neg = neg;
    next_step = step;
    next_mag = mag;
    next_rem = rem;
    next_dvs = dvs;
    next_done = 1'b0;
    next_quotient = quotient;
    if (start)
    begin
      next_busy = 1'b1;
      next_neg = dividend[WIA_SUMW-1];
      next_mag = dividend[WIA_SUMW-1] ? WIA_SUMW'(-dividend) : dividend;
      next_rem = '0;
      next_dvs = divisor;
      next_step = '0;
    end
    else if (busy)
    begin
      next_rem = bit_q ? (shifted - {1'b0, dvs}) : shifted;
      next_mag = {mag[WIA_SUMW-2:0], bit_q};
      next_step = step + 6'h01;
      if (step == 6'(WIA_DIV_STEPS - 1))
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_quotient = neg ? WIA_SUMW'(-{mag[WIA_SUMW-2:0], bit_q})
                            : {mag[WIA_SUMW-2:0], bit_q};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      neg <= 1'b0;
      step <= '0;
      mag <= '0;
      rem <= '0;
      dvs <= '0;
      done <= 1'b0;
      quotient <= '0;
    end
    else
    begin
      busy <= next_busy;
      neg <= next_neg;
      step <= next_step;
      mag <= next_mag;
      rem <= next_rem;
      dvs <= next_dvs;
      done <= next_done;
      quotient <= next_quotient;
    end
  end

endmodule

// ==== wia_averager.sv ====
// wia_averager: per-channel windowed running-mean filter with an apb register file
// assumes samples arrive in display counts from logic on pclk, so no synchroniser
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps

module wia_averager
  import wia_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WIA_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire wia_sample_t sample,
  output logic result_valid,
  input wire logic result_ready,
  output wia_result_t result
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [WIA_SUMW-1:0] sext(input logic [WIA_DW-1:0] d);
    return {{(WIA_SUMW-WIA_DW){d[WIA_DW-1]}}, d};
  endfunction

  // inside when twice the distance from the centre is at most the width
  function automatic logic in_window(input logic [WIA_DW-1:0] s,
                                     input logic [WIA_DW-1:0] c,
                                     input logic [WIA_WW-1:0] w);
    logic [WIA_DW:0] diff;
    logic [WIA_DW:0] mag;
    diff = {s[WIA_DW-1], s} - {c[WIA_DW-1], c};
    mag = diff[WIA_DW] ? (WIA_DW+1)'(-diff) : diff;
    return {mag, 1'b0} <= {{(WIA_DW+2-WIA_WW){1'b0}}, w};
  endfunction

  // ****************************************
  // state
  // ****************************************
  wia_state_t state, next_state;
  wia_sample_t cur, next_cur;
  wia_result_t next_result;
  logic [11:0] cal_code, next_cal_code;
  logic [WIA_NW-1:0] n_set [WIA_NCH];
  logic [WIA_NW-1:0] next_n_set [WIA_NCH];
  logic [WIA_WW-1:0] w_set [WIA_NCH];
  logic [WIA_WW-1:0] next_w_set [WIA_NCH];
  logic [WIA_DW-1:0] centre [WIA_NCH];
  logic [WIA_DW-1:0] next_centre [WIA_NCH];
  logic [WIA_SUMW-1:0] sum [WIA_NCH];
  logic [WIA_SUMW-1:0] next_sum [WIA_NCH];
  logic [WIA_NW-1:0] cnt [WIA_NCH];
  logic [WIA_NW-1:0] next_cnt [WIA_NCH];
  logic [WIA_IDXW-1:0] wp [WIA_NCH];
  logic [WIA_IDXW-1:0] next_wp [WIA_NCH];
  logic [WIA_NCH-1:0] restart, next_restart;
  logic [31:0] next_prdata;
  logic next_pslverr;

  logic [WIA_CHW-1:0] ch;
  logic [WIA_CHW-1:0] sel_ch;
  logic sel_ok;
  logic win_ok;
  logic acc_err;
  logic apb_wr;
  logic mem_we;
  logic [WIA_CHW+WIA_IDXW-1:0] mem_waddr;
  logic [WIA_DW-1:0] mem_rdata;
  logic div_start;
  logic div_done;
  logic [WIA_SUMW-1:0] div_dividend;
  logic [WIA_NW-1:0] div_divisor;
  logic [WIA_SUMW-1:0] div_q;

  assign ch = cur.chan;
  assign sel_ok = (cal_code >= WIA_CODE_CH_FIRST) && (cal_code <= WIA_CODE_CH_LAST);
  assign sel_ch = WIA_CHW'(cal_code - WIA_CODE_CH_FIRST);
  assign win_ok = in_window(cur.data, centre[ch], w_set[ch]);
  assign sample_ready = (state == WIA_IDLE);
  assign result_valid = (state == WIA_OUT);
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;

  // ****************************************
  // apb decode
  // ****************************************
  // settings registers only reachable while a valid channel code is selected
  always_comb
  begin
    acc_err = 1'b0;
    case (paddr)
      WIA_OFF_CAL_CODE: acc_err = 1'b0;
      WIA_OFF_COUNT, WIA_OFF_WIDTH: acc_err = !sel_ok;
      WIA_OFF_STATUS, WIA_OFF_LAST: acc_err = pwrite;
      default: acc_err = 1'b1;
    endcase
  end

  // read data is captured in the setup phase so prdata comes from flops
  always_comb
  begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable)
    begin
      next_pslverr = acc_err;
      next_prdata = '0;
      if (!acc_err && !pwrite)
      begin
        case (paddr)
          WIA_OFF_CAL_CODE: next_prdata = {20'h00000, cal_code};
          WIA_OFF_COUNT: next_prdata = {24'h000000, n_set[sel_ch]};
          WIA_OFF_WIDTH: next_prdata = {16'h0000, w_set[sel_ch]};
          WIA_OFF_STATUS:
          begin
            next_prdata[WIA_ST_BUSY] = (state != WIA_IDLE);
            next_prdata[WIA_ST_SEL_OK] = sel_ok;
            next_prdata[WIA_ST_AVG_LSB +: WIA_NCH] = ~restart;
          end
          WIA_OFF_LAST: next_prdata = sext(result.data);
          default: next_prdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // filter datapath
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_result = result;
    next_cal_code = cal_code;
    next_n_set = n_set;
    next_w_set = w_set;
    next_centre = centre;
    next_sum = sum;
    next_cnt = cnt;
    next_wp = wp;
    next_restart = restart;
    mem_we = 1'b0;
    mem_waddr = '0;
    div_start = 1'b0;
    unique case (state)
      WIA_IDLE:
      begin
        if (sample_valid)
        begin
          next_cur = sample;
          next_state = WIA_FETCH;
        end
      end
      WIA_FETCH:
      begin
        mem_we = 1'b1;
        if (restart[ch] || !win_ok)
        begin
          // raw value out, history restarted around it
          next_centre[ch] = cur.data;
          next_sum[ch] = sext(cur.data);
          next_cnt[ch] = WIA_N_MIN;
          next_wp[ch] = (n_set[ch] == WIA_N_MIN) ? '0 : WIA_IDXW'(1);
          next_restart[ch] = 1'b0;
          mem_waddr = {ch, {WIA_IDXW{1'b0}}};
          next_result = '{chan: ch, averaged: 1'b0, data: cur.data};
          next_state = WIA_OUT;
        end
        else
        begin
          mem_waddr = {ch, wp[ch]};
          if (cnt[ch] >= n_set[ch])
          begin
            // full ring: the slot about to be overwritten holds the oldest
            next_sum[ch] = sum[ch] - sext(mem_rdata) + sext(cur.data);
          end
          else
          begin
            next_sum[ch] = sum[ch] + sext(cur.data);
            next_cnt[ch] = cnt[ch] + 8'h01;
          end
          next_wp[ch] = (wp[ch] + 8'h01 >= n_set[ch]) ? '0 : wp[ch] + 8'h01;
          div_start = 1'b1;
          next_state = WIA_DIV;
        end
      end
      WIA_DIV:
      begin
        if (div_done)
        begin
          next_result = '{chan: ch, averaged: 1'b1, data: div_q[WIA_DW-1:0]};
          next_state = WIA_OUT;
        end
      end
      WIA_OUT:
      begin
        if (result_ready)
        begin
          next_state = WIA_IDLE;
        end
      end
      default: next_state = WIA_IDLE;
    endcase
    // register writes come last so a restart request beats the datapath clear
    if (apb_wr && !acc_err)
    begin
      case (paddr)
        WIA_OFF_CAL_CODE: next_cal_code = pwdata[11:0];
        WIA_OFF_COUNT:
        begin
          next_n_set[sel_ch] = (pwdata[7:0] == 8'h00) ? WIA_N_MIN : pwdata[7:0];
          next_restart[sel_ch] = 1'b1;
          // a shorter ring must not keep a count above its new length
          next_cnt[sel_ch] = '0;
        end
        WIA_OFF_WIDTH:
        begin
          next_w_set[sel_ch] = (pwdata[15:0] == 16'h0000) ? WIA_W_MIN : pwdata[15:0];
          next_restart[sel_ch] = 1'b1;
        end
        default: next_cal_code = cal_code;
      endcase
    end
  end

  assign div_dividend = next_sum[ch];
  assign div_divisor = next_cnt[ch];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= WIA_IDLE;
      cur <= '0;
      result <= '0;
      cal_code <= WIA_CAL_CODE_RST;
      restart <= '1;
      for (int i = 0; i < WIA_NCH; i++)
      begin
        n_set[i] <= WIA_N_RST;
        w_set[i] <= WIA_W_RST;
        centre[i] <= '0;
        sum[i] <= '0;
        cnt[i] <= '0;
        wp[i] <= '0;
      end
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      result <= next_result;
      cal_code <= next_cal_code;
      restart <= next_restart;
      n_set <= next_n_set;
      w_set <= next_w_set;
      centre <= next_centre;
      sum <= next_sum;
      cnt <= next_cnt;
      wp <= next_wp;
    end
  end

  // ****************************************
  // submodules
  // ****************************************
  wia_hist u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(cur.data),
    .raddr({sample.chan, wp[sample.chan]}),
    .rdata(mem_rdata)
  );

  wia_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .dividend(div_dividend),
    .divisor(div_divisor),
    .done(div_done),
    .quotient(div_q)
  );

  // ****************************************
  // assertions
  // ****************************************
  logic any_n_zero;
  logic any_w_zero;
  always_comb
  begin
    any_n_zero = 1'b0;
    any_w_zero = 1'b0;
    for (int i = 0; i < WIA_NCH; i++)
    begin
      any_n_zero = any_n_zero | (n_set[i] == 8'h00);
      any_w_zero = any_w_zero | (w_set[i] == 16'h0000);
    end
  end

  property p_len_range;
    @(posedge pclk) disable iff (!presetn) !any_n_zero && (cnt[ch] <= n_set[ch]);
  endproperty
  a_len_range: assert property (p_len_range) else $error("sample count out of range");

  property p_width_range;
    @(posedge pclk) disable iff (!presetn) !any_w_zero;
  endproperty
  a_width_range: assert property (p_width_range) else $error("window width zero");

  property p_mean_in_window;
    @(posedge pclk) disable iff (!presetn)
      (state == WIA_DIV && div_done && !restart[ch])
      |=> in_window(result.data, centre[ch], w_set[ch]);
  endproperty
  a_mean_in_window: assert property (p_mean_in_window) else $error("mean left the window");

  property p_avg_path;
    @(posedge pclk) disable iff (!presetn)
      (state == WIA_FETCH && !restart[ch] && win_ok)
      |=> (state == WIA_DIV) ##[1:34] (state == WIA_OUT && result.averaged);
  endproperty
  a_avg_path: assert property (p_avg_path) else $error("in-window sample not averaged");

  property p_raw_out;
    @(posedge pclk) disable iff (!presetn)
      (state == WIA_FETCH && !win_ok)
      |=> (state == WIA_OUT) && !result.averaged && (result.data == $past(cur.data));
  endproperty
  a_raw_out: assert property (p_raw_out) else $error("excursion not passed raw");

  property p_new_centre;
    @(posedge pclk) disable iff (!presetn)
      (state == WIA_FETCH && !win_ok) |=> (centre[$past(ch)] == $past(cur.data));
  endproperty
  a_new_centre: assert property (p_new_centre) else $error("window not re-centred");

  property p_sel_err;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !sel_ok && (paddr == WIA_OFF_COUNT || paddr == WIA_OFF_WIDTH))
      |=> pslverr;
  endproperty
  a_sel_err: assert property (p_sel_err) else $error("setting access without channel code");

  property p_restart_one;
    @(posedge pclk) disable iff (!presetn)
      (state == WIA_FETCH && (restart[ch] || !win_ok))
      |=> (cnt[$past(ch)] == 8'h01) && (sum[$past(ch)] == sext($past(cur.data)));
  endproperty
  a_restart_one: assert property (p_restart_one) else $error("accumulation not restarted");

endmodule

// ==== wia_src.sv ====
// wia_src: model of the input signal conditioner that feeds channel samples
// assumes the bench asks for one sample at a time, all on pclk
`timescale 1ns/100ps
module wia_src
  import wia_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire wia_sample_t req,
  input wire logic sample_ready,
  output logic sample_valid,
  output wia_sample_t sample
);
  // ****************************************
  // offer held until the averager takes it
  // ****************************************
  // once taken the bus shows the inverse word, so a late read cannot pass by luck
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_valid <= 1'b0;
      sample <= '0;
    end
    else if (go)
    begin
      sample_valid <= 1'b1;
      sample <= req;
    end
    else if (sample_valid && sample_ready)
    begin
      sample_valid <= 1'b0;
      sample <= ~sample;
    end
  end
endmodule

// ==== test_windowed_input_averager.sv ====
// test_windowed_input_averager: self-checking bench for the windowed averager
// assumes wia_src as sample source and the bench as apb master and result sink
`timescale 1ns/100ps
module test_windowed_input_averager
  import wia_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go;
  logic [WIA_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sample_valid, sample_ready, result_valid, result_ready;
  wia_sample_t sample, req;
  wia_result_t result;
  int num_errors, cmp_count, seed, k, d, c;
  int nset[4], wset[4], cen[4];
  bit rst[4];
  int hist[4][$];

  wia_averager uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample(sample), .result_valid(result_valid), .result_ready(result_ready),
    .result(result));
  wia_src src (.pclk(pclk), .presetn(presetn), .go(go), .req(req),
    .sample_ready(sample_ready), .sample_valid(sample_valid), .sample(sample));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_res(input wia_result_t exp, input wia_result_t got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error result expected %h seen %h", exp, got);
    end
  endtask

  // request held until the edge that sees pready high; data taken there
  task automatic acc(input logic w, input logic [WIA_AW-1:0] a, input logic [31:0] wd,
                     input logic [31:0] xd, input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, xe}, {31'h0, er});
    if (!w)
      chk("prdata", xd, rd);
  endtask

  task automatic setch(input int ch, input int n, input int w);
    nset[ch] = (n == 0) ? 1 : n;
    wset[ch] = (w == 0) ? 1 : w;
    rst[ch] = 1'b1;
    acc(1'b1, WIA_OFF_CAL_CODE, 32'(WIA_CODE_CH_FIRST) + 32'(ch), '0, 1'b0);
    acc(1'b1, WIA_OFF_COUNT, 32'(n), '0, 1'b0);
    acc(1'b1, WIA_OFF_WIDTH, 32'(w), '0, 1'b0);
    acc(1'b0, WIA_OFF_COUNT, '0, 32'(nset[ch]), 1'b0);
    acc(1'b0, WIA_OFF_WIDTH, '0, 32'(wset[ch]), 1'b0);
    acc(1'b0, WIA_OFF_CAL_CODE, '0, 32'(WIA_CODE_CH_FIRST) + 32'(ch), 1'b0);
  endtask

  // ****************************************
  // sample path with its reference model
  // ****************************************
  task automatic put(input int ch, input int v);
    wia_result_t x;
    int s;
    x.chan = ch[1:0];
    x.data = v[23:0];
    x.averaged = 1'b1;
    if (rst[ch] || 2 * ((v > cen[ch]) ? v - cen[ch] : cen[ch] - v) > wset[ch])
    begin
      x.averaged = 1'b0;
      rst[ch] = 1'b0;
      cen[ch] = v;
      hist[ch] = {v};
    end
    else
    begin
      hist[ch].push_back(v);
      if (hist[ch].size() > nset[ch])
        void'(hist[ch].pop_front());
      s = hist[ch].sum();
      x.data = 24'(s / hist[ch].size());
    end
    @(posedge pclk);
    go <= 1'b1;
    req <= {ch[1:0], v[23:0]};
    @(posedge pclk);
    go <= 1'b0;
    do
      @(negedge pclk);
    while (result_valid !== 1'b1);
    repeat ($unsigned($random(seed)) % 3)
      @(posedge pclk);
    chk_res(x, result);
    @(posedge pclk);
    result_ready <= 1'b1;
    @(posedge pclk);
    result_ready <= 1'b0;
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard sized well above the expected few thousand cycles
  initial
  begin
    #5000000;
    num_errors++;
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 74;
    {presetn, psel, penable, pwrite, go, result_ready} = '0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    for (k = 0; k < 4; k++)
    begin
      nset[k] = 1;
      wset[k] = 65535;
      rst[k] = 1'b1;
      cen[k] = 0;
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, WIA_OFF_CAL_CODE, '0, 32'h0, 1'b0);
    acc(1'b0, WIA_OFF_STATUS, '0, 32'h0, 1'b0);
    acc(1'b0, WIA_OFF_COUNT, '0, 32'h0, 1'b1);
    acc(1'b1, WIA_OFF_WIDTH, 32'h5, '0, 1'b1);
    acc(1'b0, 8'h14, '0, 32'h0, 1'b1);
    acc(1'b1, WIA_OFF_STATUS, 32'h1, '0, 1'b1);
    acc(1'b1, WIA_OFF_CAL_CODE, 32'h0E1, '0, 1'b0);
    acc(1'b0, WIA_OFF_STATUS, '0, 32'h0, 1'b0);
    acc(1'b1, WIA_OFF_CAL_CODE, 32'h0DD, '0, 1'b0);
    acc(1'b0, WIA_OFF_COUNT, '0, 32'h1, 1'b0);
    acc(1'b0, WIA_OFF_WIDTH, '0, 32'hFFFF, 1'b0);
    acc(1'b0, WIA_OFF_STATUS, '0, 32'h2, 1'b0);
    setch(0, 3, 1000);
    setch(1, 255, 65535);
    setch(2, 0, 0);
    setch(3, 1 + $unsigned($random(seed)) % 255, 1 + $unsigned($random(seed)) % 65535);
    put(0, 100);
    put(0, 600);
    put(0, -399);
    put(0, -400);
    acc(1'b0, WIA_OFF_LAST, '0, 32'hFFFFFFBE, 1'b0);
    put(0, 601);
    put(0, 601);
    put(2, 5);
    put(2, 5);
    put(2, 6);
    for (k = 0; k < 150; k++)
    begin
      c = $unsigned($random(seed)) % 4;
      if ($unsigned($random(seed)) % 5 == 0)
        d = (cen[c] + $random(seed) % 100000) % 4000000;
      else
        d = cen[c] + $random(seed) % (wset[c] / 2 + 1);
      put(c, d);
    end
    setch(1, 2, 50);
    put(1, cen[1]);
    acc(1'b0, WIA_OFF_STATUS, '0, 32'h2 | 32'({~rst[3], ~rst[2], ~rst[1], ~rst[0]}) << 4,
        1'b0);
    final_report();
  end
endmodule
